// File: common/smcc_pkg.sv
// package: register map, field layout and supply scaling for the supply monitor clamp config
package smcc_pkg;

  localparam logic [7:0] SMCC_OFS_GUARD_CFG     = 8'h09;
  localparam logic [7:0] SMCC_OFS_THRESH_FIRST  = 8'h0A;
  localparam logic [7:0] SMCC_OFS_THRESH_SECOND = 8'h0B;

  localparam logic [7:0] SMCC_RST_GUARD_CFG     = 8'h00;
  localparam logic [7:0] SMCC_RST_THRESH_FIRST  = 8'h92;
  localparam logic [7:0] SMCC_RST_THRESH_SECOND = 8'h8D;

  // supply_guard_config field positions
  localparam int SMCC_PLE_MSB  = 7;
  localparam int SMCC_PLE_LSB  = 6;
  localparam int SMCC_UVT_MSB  = 2;
  localparam int SMCC_UVT_LSB  = 0;

  // preservation_level_enable codes
  localparam logic [1:0] SMCC_PLE_OFF   = 2'h0;
  localparam logic [1:0] SMCC_PLE_FIRST = 2'h1;
  localparam logic [1:0] SMCC_PLE_BOTH  = 2'h2;

  // supply reading scale and lockout threshold ladder
  localparam int SMCC_SUPPLY_LSB_MV = 25;
  localparam int SMCC_UNDERVOLTAGE_LOCKOUT_BASE_MV  = 2500;
  localparam int SMCC_UNDERVOLTAGE_LOCKOUT_STEP_MV  = 100;
  localparam logic [7:0] SMCC_UNDERVOLTAGE_LOCKOUT_BASE_CODE = 8'(SMCC_UNDERVOLTAGE_LOCKOUT_BASE_MV / SMCC_SUPPLY_LSB_MV);
  localparam logic [7:0] SMCC_UNDERVOLTAGE_LOCKOUT_STEP_CODE = 8'(SMCC_UNDERVOLTAGE_LOCKOUT_STEP_MV / SMCC_SUPPLY_LSB_MV);

  typedef enum logic [1:0] {
    SMCC_CLAMP_NONE,
    SMCC_CLAMP_FIRST,
    SMCC_CLAMP_SECOND
  } smcc_clamp_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } smcc_req_s;

endpackage : smcc_pkg

// File: design/smcc_clamp_select.sv
// module: samples supply once per effect start and holds the clamp choice
`timescale 1ns/10ps
`default_nettype none
module smcc_clamp_select
  import smcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        effect_start,
  input  wire logic [7:0]  supply_code,
  input  wire logic [1:0]  level_enable,
  input  wire logic [7:0]  thresh_first,
  input  wire logic [7:0]  thresh_second,
  output var  smcc_clamp_e clamp_sel
);

  smcc_clamp_e clamp_reg;
  smcc_clamp_e clamp_next;
  logic        first_on;
  logic        second_on;
  logic        below_first;
  logic        below_second;

  // code 3 handled as both levels enabled
  assign first_on     = (level_enable != SMCC_PLE_OFF);
  assign second_on    = (level_enable[1] == 1'b1);
  assign below_first  = (supply_code < thresh_first);
  assign below_second = (supply_code < thresh_second);

  always_comb begin
    clamp_next = clamp_reg;
    if (effect_start) begin
      if (second_on && below_second) begin
        clamp_next = SMCC_CLAMP_SECOND;
      end else if (first_on && below_first) begin
        clamp_next = SMCC_CLAMP_FIRST;
      end else begin
        clamp_next = SMCC_CLAMP_NONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clamp_reg <= SMCC_CLAMP_NONE;
    end else begin
      clamp_reg <= clamp_next;
    end
  end

  assign clamp_sel = clamp_reg;

endmodule : smcc_clamp_select
`default_nettype wire

// File: design/smcc_top.sv
// module: supply guard registers, lockout detection and per-effect clamp selection
//
// Contract
// - preservation enable code 0 off, 1 first level, 2 first and second levels.
// - lockout code maps linearly, 0.1 V steps, code 0 2.5 V to 7 3.2 V.
// - supply below lockout threshold turns output stage off and forces standby three clocks later (two sync stages, then output register).
// - first level enabled and supply below first threshold selects first clamp, unless the second clamp condition also holds.
// - second level enabled and supply below second threshold selects second clamp.
// - supply sampled only at effect start; choice held for the whole effect.
`timescale 1ns/10ps
`default_nettype none
module smcc_top
  import smcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire smcc_req_s   reg_req,
  output var  logic [7:0]  reg_rdata,
  input  wire logic [7:0]  supply_code,
  input  wire logic        effect_start,
  output var  logic        output_stage_en,
  output var  logic        standby_force,
  output var  smcc_clamp_e clamp_sel
);

  logic [7:0] guard_cfg_reg;
  logic [7:0] thresh_first_reg;
  logic [7:0] thresh_second_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] supply_meta_reg;
  logic [7:0] supply_sync_reg;
  logic       stage_en_reg;
  logic       standby_reg;

  logic       hit_cfg;
  logic       hit_first;
  logic       hit_second;
  logic [2:0] undervoltage_lockout_code;
  logic [7:0] undervoltage_lockout_thresh;
  logic       undervoltage_lockout_trip;

  // register decode
  assign hit_cfg    = (reg_req.addr == SMCC_OFS_GUARD_CFG);
  assign hit_first  = (reg_req.addr == SMCC_OFS_THRESH_FIRST);
  assign hit_second = (reg_req.addr == SMCC_OFS_THRESH_SECOND);

  always_comb begin
    if (hit_cfg) begin
      rdata_next = guard_cfg_reg;
    end else if (hit_first) begin
      rdata_next = thresh_first_reg;
    end else if (hit_second) begin
      rdata_next = thresh_second_reg;
    end else begin
      rdata_next = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      guard_cfg_reg     <= SMCC_RST_GUARD_CFG;
      thresh_first_reg  <= SMCC_RST_THRESH_FIRST;
      thresh_second_reg <= SMCC_RST_THRESH_SECOND;
    end else if (reg_req.wr) begin
      if (hit_cfg) begin
        guard_cfg_reg <= reg_req.wdata;
      end
      if (hit_first) begin
        thresh_first_reg <= reg_req.wdata;
      end
      if (hit_second) begin
        thresh_second_reg <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 8'h00;
    end else if (reg_req.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  // supply reading arrives from the measurement path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_meta_reg <= 8'h00;
      supply_sync_reg <= 8'h00;
    end else begin
      supply_meta_reg <= supply_code;
      supply_sync_reg <= supply_meta_reg;
    end
  end

  // lockout ladder in supply code units
  assign undervoltage_lockout_code   = guard_cfg_reg[SMCC_UVT_MSB:SMCC_UVT_LSB];
  assign undervoltage_lockout_thresh = 8'(SMCC_UNDERVOLTAGE_LOCKOUT_BASE_CODE + 8'(undervoltage_lockout_code) * SMCC_UNDERVOLTAGE_LOCKOUT_STEP_CODE);
  assign undervoltage_lockout_trip   = (supply_sync_reg < undervoltage_lockout_thresh);

  // reset state: stage off until first valid reading
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_en_reg <= 1'b0;
      standby_reg  <= 1'b1;
    end else begin
      stage_en_reg <= !undervoltage_lockout_trip;
      standby_reg  <= undervoltage_lockout_trip;
    end
  end

  smcc_clamp_select u_clamp_select (
    .clk           (clk),
    .rst_n         (rst_n),
    .effect_start  (effect_start),
    .supply_code   (supply_sync_reg),
    .level_enable  (guard_cfg_reg[SMCC_PLE_MSB:SMCC_PLE_LSB]),
    .thresh_first  (thresh_first_reg),
    .thresh_second (thresh_second_reg),
    .clamp_sel     (clamp_sel)
  );

  assign reg_rdata       = rdata_reg;
  assign output_stage_en = stage_en_reg;
  assign standby_force   = standby_reg;

endmodule : smcc_top
`default_nettype wire

// File: bench/smcc_top_chk.sv
// checker: lockout and clamp choice properties
`timescale 1ns/10ps
`default_nettype none
module smcc_top_chk
  import smcc_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire smcc_req_s   reg_req,
  input wire logic [7:0]  supply_code,
  input wire logic        effect_start,
  input wire logic        output_stage_en,
  input wire logic        standby_force,
  input wire smcc_clamp_e clamp_sel
);
  logic [7:0] cfg_reg, prv_reg;
  logic [2:0] q_reg;
  // supply and registers quiet long enough to settle
  wire logic  sq = supply_code == prv_reg && q_reg > 3'h3;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= 8'h00;
      prv_reg <= 8'h00;
      q_reg <= 3'h0;
    end else begin
      prv_reg <= supply_code;
      q_reg <= (reg_req.wr || supply_code != prv_reg) ? 3'h0 : q_reg + 3'(q_reg != 3'h7);
      if (reg_req.wr && reg_req.addr == 8'h09) cfg_reg <= reg_req.wdata;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_lockout_trip: assert property (
    sq && supply_code < 8'h64 |-> !output_stage_en && standby_force) else $error("stage on");
  a_lockout_step: assert property (
    sq |-> standby_force == (supply_code < 8'h64 + {cfg_reg[2:0], 2'h0})) else $error("bad trip");
  a_level_off: assert property (
    effect_start && cfg_reg[7:6] == 2'h0 |=> clamp_sel == SMCC_CLAMP_NONE) else $error("clamp when off");
  a_first_clamp: assert property (
    effect_start && sq && cfg_reg[7:6] == 2'h1 && supply_code < 8'h92 |=> clamp_sel == SMCC_CLAMP_FIRST)
    else $error("no first");
  a_second_clamp: assert property (
    effect_start && sq && cfg_reg[7] && supply_code < 8'h8D |=> clamp_sel == SMCC_CLAMP_SECOND)
    else $error("no second");
  a_clamp_hold: assert property (
    !effect_start |=> $stable(clamp_sel)) else $error("clamp moved");
endmodule : smcc_top_chk
bind smcc_top smcc_top_chk u_chk (.clk, .rst_n, .reg_req, .supply_code, .effect_start, .output_stage_en,
  .standby_force, .clamp_sel);
`default_nettype wire

// File: bench/test_smcc_top.sv
// testbench: registers, lockout ladder, clamp choice
`timescale 1ns/10ps
`default_nettype none
module test_smcc_top import smcc_pkg::*;;
  logic        clk, rst_n, effect_start, output_stage_en, standby_force;
  logic [7:0]  supply_code, reg_rdata, v;
  logic [1:0]  l;
  smcc_req_s   reg_req;
  smcc_clamp_e clamp_sel;
  int          fails, checks, seed, i;
  smcc_top u_smcc_top (.clk, .rst_n, .reg_req, .reg_rdata, .supply_code, .effect_start, .output_stage_en,
    .standby_force, .clamp_sel);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{w, !w, a, d};
    @(posedge clk);
    reg_req <= '0;
    cyc(1);
  endtask : acc
  function automatic logic [7:0] pick(input logic [1:0] lv, input logic [7:0] s);
    if (lv == 2'h0) return 8'h00;
    if (lv[1] && s < 8'h8D) return 8'h02;
    return {7'h0, s < 8'h92};
  endfunction : pick
  task automatic report_and_stop;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial begin
    seed = 16085;
    rst_n = 0;
    effect_start = 0;
    supply_code = 8'hC8;
    reg_req = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    // reset values, then one unmapped read
    for (i = 0; i < 4; i++) begin
      acc(0, 8'(9 + i), 8'h00);
      cmp(reg_rdata, i == 1 ? 8'h92 : i == 2 ? 8'h8D : 8'h00);
    end
    for (i = 0; i < 16; i++) begin
      if (i % 2 == 0) acc(1, 8'h09, 8'(i / 2));
      @(posedge clk);
      supply_code <= 8'h63 + 8'(i / 2 * 4 + i % 2);
      cyc(6);
      cmp({6'h0, output_stage_en, standby_force}, i % 2 ? 8'h02 : 8'h01);
    end
    for (i = 0; i < 60; i++) begin
      l = 2'($random(seed) & 3);
      // thresholds stay at reset, first above second
      v = 8'h88 + 8'($random(seed) & 15);
      acc(1, 8'h09, {l, 6'h0});
      acc(0, 8'h09, 8'h00);
      cmp(reg_rdata, {l, 6'h0});
      @(posedge clk);
      supply_code <= v;
      repeat (6) @(posedge clk);
      effect_start <= 1;
      @(posedge clk);
      effect_start <= 0;
      supply_code <= ~v;
      #1 cmp(8'(clamp_sel), pick(l, v));
      cyc(4);
      cmp(8'(clamp_sel), pick(l, v));
    end
    report_and_stop();
  end
endmodule : test_smcc_top
`default_nettype wire
